// ==== src/scc_top.sv ====
// The strobed register port was decided locally.
`timescale 1ns/1ps
module scc_top
  import scc_pkg::*;
#(
  parameter int LOCK_STAGES = 16,
  parameter int PERIOD_W = 8
)
(
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic HIGH_OSC_CLOCK_IN,
  input wire logic LOW_OSC_CLOCK_IN,
  output logic [7:0] RDATA_OUT,
  output logic HIGH_OSC_ENABLE_OUT,
  output logic LOW_OSC_ENABLE_OUT,
  output logic HIGH_OSC_DRIVE_OUT,
  output logic LOW_OSC_DRIVE_OUT,
  output logic EXTERNAL_CLOCK_OUT,
  output logic [1:0] HALT_MODE_OUT,
  output logic PLL_CLOCK_OUT,
  output logic SYS_CLOCK_OUT,
  output logic IRQ_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] hi_sync;
    logic [2:0] lo_sync;
    logic hi_en;
    logic lo_en;
    logic src_req;
    logic [2:0] gear_req;
    logic src_act;
    logic [2:0] gear_act;
    logic spare7;
    logic [1:0] warm_sel;
    logic [1:0] halt_mode;
    logic protect;
    logic key_armed;
    logic ext_clk;
    logic drv_hi;
    logic drv_lo;
    logic fc_sel;
    logic pll_on;
    logic locked;
    logic [LOCK_STAGES-1:0] lock_cnt;
    scc_wu_type wu;
    logic wu_tgt;
    logic [15:0] wu_cnt;
    logic [PERIOD_W-1:0] per_cnt;
    logic [PERIOD_W-1:0] per_len;
    logic [PERIOD_W-1:0] ph_cnt;
    logic [1:0] sub_cnt;
    logic pll_clk;
    logic [3:0] div_cnt;
    logic sys_clk;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic [7:0] rdata;
  } scc_state_type;

  localparam logic [LOCK_STAGES-1:0] LOCK_LAST = '1;
  localparam logic [PERIOD_W-1:0] PER_ONE = PERIOD_W'(1);
  localparam logic [PERIOD_W-1:0] PER_MAX = '1;

  scc_state_type q;
  scc_state_type nxt_q;
  scc_bus_type bus;
  logic hi_rise;
  logic lo_rise;
  logic tgt_rise;
  logic pll_tick;
  logic fc_tick;
  logic mid_tick;
  logic warm_start;
  logic warm_done;
  logic lock_done;
  logic [PERIOD_W-1:0] quarter;

  assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // ----------------------------------------------------------------
  // Oscillator edges (sampled after two flops)
  // ----------------------------------------------------------------
  // A stopped oscillator yields no edges even if its pin still toggles
  assign hi_rise = q.hi_sync[1] & ~q.hi_sync[2] & q.hi_en;
  assign lo_rise = q.lo_sync[1] & ~q.lo_sync[2] & q.lo_en;
  assign tgt_rise = q.wu_tgt ? lo_rise : hi_rise;

  // Four evenly spread ticks per fast oscillator period; the quarter is
  // truncated, so the spacing is only as fine as the sampling clock allows
  assign quarter = (q.per_len >> 2) == '0 ? PER_ONE : (q.per_len >> 2);
  assign mid_tick = (q.ph_cnt == quarter) && (q.sub_cnt != LAST_SUB_TICK);
  assign pll_tick = q.pll_on & (hi_rise | mid_tick);
  assign fc_tick = q.fc_sel ? pll_tick : hi_rise;

  assign warm_start = bus.wr && bus.addr == ADDR_OSC_CTRL && bus.wdata[BIT_WARM]
    && q.warm_sel != WARM_SEL_RSVD;
  assign warm_done = q.wu == SCC_WU_RUN && tgt_rise
    && q.wu_cnt == scc_warm_last(q.warm_sel);
  assign lock_done = q.pll_on && !q.locked && hi_rise && q.lock_cnt == LOCK_LAST;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_q = q;
    nxt_q.hi_sync = {q.hi_sync[1:0], HIGH_OSC_CLOCK_IN};
    nxt_q.lo_sync = {q.lo_sync[1:0], LOW_OSC_CLOCK_IN};

    // PLL period measurement and tick phase
    if (hi_rise)
    begin
      nxt_q.per_len = q.per_cnt;
      nxt_q.per_cnt = PER_ONE;
      nxt_q.ph_cnt = PER_ONE;
      nxt_q.sub_cnt = '0;
    end
    else
    begin
      if (q.per_cnt != PER_MAX)
      begin
        nxt_q.per_cnt = q.per_cnt + PER_ONE;
      end
      if (mid_tick)
      begin
        nxt_q.ph_cnt = PER_ONE;
        nxt_q.sub_cnt = q.sub_cnt + 2'h1;
      end
      else if (q.ph_cnt != PER_MAX)
      begin
        nxt_q.ph_cnt = q.ph_cnt + PER_ONE;
      end
    end
    if (pll_tick)
    begin
      nxt_q.pll_clk = ~q.pll_clk;
    end

    // PLL lock-up counter restarts whenever the PLL is off
    if (!q.pll_on)
    begin
      nxt_q.lock_cnt = '0;
      nxt_q.locked = 1'b0;
    end
    else if (lock_done)
    begin
      nxt_q.locked = 1'b1;
    end
    else if (hi_rise && !q.locked)
    begin
      nxt_q.lock_cnt = q.lock_cnt + 1'b1;
    end

    // System clock: divide the fast clock by the gear, or follow the slow clock
    if (q.src_act)
    begin
      nxt_q.div_cnt = '0;
      if (lo_rise)
      begin
        nxt_q.sys_clk = ~q.sys_clk;
      end
    end
    else if (fc_tick)
    begin
      if (q.div_cnt >= scc_div_last(q.gear_act))
      begin
        nxt_q.div_cnt = '0;
        nxt_q.sys_clk = ~q.sys_clk;
      end
      else
      begin
        nxt_q.div_cnt = q.div_cnt + 4'h1;
      end
    end

    // Warm-up: requested source and gear pass through only while idle
    case (q.wu)
      SCC_WU_IDLE:
      begin
        nxt_q.src_act = q.src_req;
        nxt_q.gear_act = q.gear_req;
        // A lower gear landing mid-count restarts the divider so it never overshoots
        if (nxt_q.div_cnt > scc_div_last(q.gear_req))
        begin
          nxt_q.div_cnt = '0;
        end
        if (warm_start)
        begin
          nxt_q.wu = SCC_WU_RUN;
          nxt_q.wu_cnt = '0;
          // The oscillator not driving the system clock is the one coming up
          nxt_q.wu_tgt = ~q.src_act;
        end
      end
      SCC_WU_RUN:
      begin
        if (warm_done)
        begin
          nxt_q.wu = SCC_WU_IDLE;
        end
        else if (tgt_rise)
        begin
          nxt_q.wu_cnt = q.wu_cnt + 16'h0001;
        end
      end
      default:
      begin
        nxt_q.wu = SCC_WU_IDLE;
      end
    endcase

    // Register writes
    if (bus.wr)
    begin
      case (bus.addr)
        ADDR_OSC_CTRL:
        begin
          nxt_q.hi_en = bus.wdata[BIT_HI_EN];
          nxt_q.lo_en = bus.wdata[BIT_LO_EN];
        end
        ADDR_CLK_SEL:
        begin
          nxt_q.src_req = bus.wdata[BIT_SRC];
          nxt_q.gear_req = bus.wdata[2:0];
        end
        ADDR_WARM_HALT:
        begin
          nxt_q.spare7 = bus.wdata[7];
          nxt_q.warm_sel = bus.wdata[5:4];
          nxt_q.halt_mode = bus.wdata[3:2];
        end
        ADDR_EMU_CTRL:
        begin
          // Protect ON freezes the pad controls against stray writes
          if (!q.protect)
          begin
            nxt_q.ext_clk = bus.wdata[BIT_EXT];
            nxt_q.drv_hi = bus.wdata[BIT_DRV_HI];
            nxt_q.drv_lo = bus.wdata[BIT_DRV_LO];
          end
        end
        ADDR_KEY_FIRST:
        begin
          nxt_q.key_armed = bus.wdata == KEY_FIRST;
        end
        ADDR_KEY_SECOND:
        begin
          nxt_q.key_armed = 1'b0;
          if (q.key_armed && bus.wdata == KEY_SECOND)
          begin
            nxt_q.protect = ~q.protect;
          end
        end
        ADDR_PLL_SEL:
        begin
          nxt_q.fc_sel = bus.wdata[BIT_FC_SEL];
        end
        ADDR_PLL_EN:
        begin
          nxt_q.pll_on = bus.wdata[BIT_PLL_ON];
        end
        ADDR_IRQ_MASK:
        begin
          nxt_q.irq_mask = bus.wdata[1:0];
        end
        default:
        begin
        end
      endcase
    end

    // Sticky events: a new event beats a same-cycle write-one clear
    if (bus.wr && bus.addr == ADDR_IRQ_STAT)
    begin
      nxt_q.irq_stat = q.irq_stat & ~bus.wdata[1:0];
    end
    if (warm_done)
    begin
      nxt_q.irq_stat[BIT_IRQ_WARM] = 1'b1;
    end
    if (lock_done)
    begin
      nxt_q.irq_stat[BIT_IRQ_LOCK] = 1'b1;
    end
    nxt_q.irq = |(q.irq_stat & q.irq_mask);

    // Reads; unassigned bits return zero, which callers must not rely on
    nxt_q.rdata = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_OSC_CTRL: nxt_q.rdata = {q.hi_en, q.lo_en, 3'h0, q.wu == SCC_WU_RUN, 2'h0};
        ADDR_CLK_SEL: nxt_q.rdata = {4'h0, q.src_req, q.gear_req};
        ADDR_WARM_HALT: nxt_q.rdata = {q.spare7, 1'b0, q.warm_sel, q.halt_mode, 2'h0};
        ADDR_EMU_CTRL: nxt_q.rdata = {q.protect, 4'h0, q.ext_clk, q.drv_hi, q.drv_lo};
        ADDR_PLL_SEL: nxt_q.rdata = {1'b0, q.fc_sel, q.locked, 5'h00};
        ADDR_PLL_EN: nxt_q.rdata = {q.pll_on, 7'h00};
        ADDR_IRQ_STAT: nxt_q.rdata = {6'h00, q.irq_stat};
        ADDR_IRQ_MASK: nxt_q.rdata = {6'h00, q.irq_mask};
        default: nxt_q.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      q <= '0;
      q.hi_en <= 1'b1;
      q.lo_en <= 1'b1;
      q.gear_req <= GEAR_RESET;
      q.gear_act <= GEAR_RESET;
      q.warm_sel <= WARM_SEL_RESET;
      q.halt_mode <= HALT_RESET;
      q.drv_hi <= 1'b1;
      q.drv_lo <= 1'b1;
      q.wu <= SCC_WU_IDLE;
      // PLL, its select and its lock flag all start cleared
    end
    else
    begin
      q <= nxt_q;
    end
  end

  assign RDATA_OUT = q.rdata;
  assign HIGH_OSC_ENABLE_OUT = q.hi_en;
  assign LOW_OSC_ENABLE_OUT = q.lo_en;
  assign HIGH_OSC_DRIVE_OUT = q.drv_hi;
  assign LOW_OSC_DRIVE_OUT = q.drv_lo;
  assign EXTERNAL_CLOCK_OUT = q.ext_clk;
  assign HALT_MODE_OUT = q.halt_mode;
  assign PLL_CLOCK_OUT = q.pll_clk;
  assign SYS_CLOCK_OUT = q.sys_clk;
  assign IRQ_OUT = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);

  chk_sys_source: assert property ($changed(q.sys_clk) |->
    ($past(q.src_act) ? $past(lo_rise) : $past(fc_tick)))
    else $error("system clock moved without a selected source edge");
  chk_gear_range: assert property (!q.src_act |-> q.div_cnt <= scc_div_last(q.gear_act))
    else $error("gear divider ran past its last count");
  chk_osc_gated: assert property ((!q.hi_en && !q.src_act && !q.pll_on) |=>
    $stable(q.div_cnt))
    else $error("stopped fast oscillator still drove the divider");
  chk_warm_hold: assert property (q.wu == SCC_WU_RUN |=>
    $stable(q.src_act) && $stable(q.gear_act))
    else $error("clock change applied during warm-up");
  chk_warm_edges: assert property ((q.wu == SCC_WU_RUN && !tgt_rise) |=>
    $stable(q.wu_cnt))
    else $error("warm-up counted without an oscillator edge");
  chk_warm_length: assert property ((q.wu == SCC_WU_RUN) ##1 (q.wu == SCC_WU_IDLE) |->
    $past(q.wu_cnt) == scc_warm_last(q.warm_sel) && q.irq_stat[BIT_IRQ_WARM])
    else $error("warm-up ended at the wrong count");
  chk_lock_count: assert property ($rose(q.locked) |->
    $past(q.lock_cnt) == LOCK_LAST && $past(hi_rise))
    else $error("lock flag rose before the full lock-up count");
  chk_lock_off: assert property (!q.pll_on |=> !q.locked && q.lock_cnt == '0)
    else $error("lock state survived PLL off");
  chk_key_toggle: assert property ($changed(q.protect) |->
    $past(q.key_armed) && $past(bus.wr) && $past(bus.addr) == ADDR_KEY_SECOND
    && $past(bus.wdata) == KEY_SECOND)
    else $error("protect flag changed without the key pair");
  chk_fast_route: assert property ((fc_tick && !hi_rise) |-> q.fc_sel && q.pll_on)
    else $error("PLL tick reached the fast clock while deselected");
  chk_irq_level: assert property (IRQ_OUT == $past(|(q.irq_stat & q.irq_mask)))
    else $error("interrupt output does not follow masked status");

endmodule

// ==== src/scc_pkg.sv ====
package scc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_OSC_CTRL = 16'h10e0;
  localparam logic [15:0] ADDR_CLK_SEL = 16'h10e1;
  localparam logic [15:0] ADDR_WARM_HALT = 16'h10e2;
  localparam logic [15:0] ADDR_EMU_CTRL = 16'h10e3;
  localparam logic [15:0] ADDR_KEY_FIRST = 16'h10e4;
  localparam logic [15:0] ADDR_KEY_SECOND = 16'h10e5;
  localparam logic [15:0] ADDR_PLL_SEL = 16'h10e8;
  localparam logic [15:0] ADDR_PLL_EN = 16'h10e9;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h10f0;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h10f1;

  // ----------------------------------------------------------------
  // Field positions, keys, reset values
  // ----------------------------------------------------------------
  localparam int BIT_HI_EN = 7;
  localparam int BIT_LO_EN = 6;
  localparam int BIT_WARM = 2;
  localparam int BIT_SRC = 3;
  localparam int BIT_PROTECT = 7;
  localparam int BIT_EXT = 2;
  localparam int BIT_DRV_HI = 1;
  localparam int BIT_DRV_LO = 0;
  localparam int BIT_FC_SEL = 6;
  localparam int BIT_LOCKED = 5;
  localparam int BIT_PLL_ON = 7;
  localparam int BIT_IRQ_WARM = 0;
  localparam int BIT_IRQ_LOCK = 1;
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'h5a;
  localparam logic [2:0] GEAR_RESET = 3'h4;
  localparam logic [1:0] WARM_SEL_RESET = 2'h2;
  localparam logic [1:0] HALT_RESET = 2'h3;
  localparam logic [1:0] WARM_SEL_RSVD = 2'h0;
  localparam logic [1:0] WARM_SEL_SHORT = 2'h1;
  localparam logic [1:0] WARM_SEL_MID = 2'h2;
  localparam logic [15:0] WARM_LAST_SHORT = 16'h00ff;
  localparam logic [15:0] WARM_LAST_MID = 16'h3fff;
  localparam logic [15:0] WARM_LAST_LONG = 16'hffff;
  localparam logic [1:0] LAST_SUB_TICK = 2'h3;

  typedef enum logic [1:0] {
    SCC_WU_IDLE = 2'b01,
    SCC_WU_RUN = 2'b10
  } scc_wu_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scc_bus_type;

  // Last count of a warm-up for each select code
  function automatic logic [15:0] scc_warm_last(input logic [1:0] sel);
    logic [15:0] r;
    r = WARM_LAST_LONG;
    if (sel == WARM_SEL_SHORT)
    begin
      r = WARM_LAST_SHORT;
    end
    else if (sel == WARM_SEL_MID)
    begin
      r = WARM_LAST_MID;
    end
    return r;
  endfunction

  // Last count of the gear divider; codes above 100 act as 100
  function automatic logic [3:0] scc_div_last(input logic [2:0] gear);
    logic [3:0] r;
    r = 4'hf;
    if (gear < GEAR_RESET)
    begin
      r = 4'((5'h01 << gear) - 5'h01);
    end
    return r;
  endfunction

endpackage

// ==== tb/tb_scc_top.sv ====
`timescale 1ns/1ps
module tb_scc_top;
  import scc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus, oscillators and the design
  // ----------------------------------------------------------------
  // Fast period of 16 clock cycles keeps the PLL quarter period exact
  localparam realtime HP = 160.0;
  localparam realtime LP = 400.0;
  localparam int LOCK = 4;
  logic clock_in;
  logic arst_n_in;
  logic [15:0] addr_in;
  logic [7:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic hosc;
  logic losc;
  logic [7:0] rdata_out;
  logic hi_en, lo_en, hi_drv, lo_drv, ext_clk, pll_clk, sys_clk, irq;
  logic [1:0] halt;
  int fails;
  int compares;
  int pll_edges;
  realtime tw;
  logic [15:0] ra [9] = '{ADDR_OSC_CTRL, ADDR_CLK_SEL, ADDR_WARM_HALT, ADDR_EMU_CTRL,
    ADDR_PLL_SEL, ADDR_PLL_EN, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 16'h10e6};
  logic [7:0] rm [9] = '{8'hc4, 8'h0f, 8'hbc, 8'h87, 8'h60, 8'h80, 8'h03, 8'h03, 8'hff};
  logic [7:0] re [9] = '{8'hc0, 8'h04, 8'h2c, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] oc [4] = '{8'h80, 8'h40, 8'h00, 8'hc0};

  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // A stopped oscillator gives a quiet pin, as the real resonator would
  initial
  begin
    hosc = 1'b0;
    forever #(HP / 2) hosc = (hi_en === 1'b1) ? ~hosc : 1'b0;
  end

  initial
  begin
    losc = 1'b0;
    forever #(LP / 2) losc = (lo_en === 1'b1) ? ~losc : 1'b0;
  end

  always @(posedge pll_clk)
  begin
    pll_edges++;
  end

  scc_top #(.LOCK_STAGES(LOCK), .PERIOD_W(8)) scc_top_inst (
    .CLOCK_IN(clock_in), .ARST_N_IN(arst_n_in), .ADDR_IN(addr_in), .WDATA_IN(wdata_in),
    .WR_IN(wr_in), .RD_IN(rd_in), .HIGH_OSC_CLOCK_IN(hosc), .LOW_OSC_CLOCK_IN(losc),
    .RDATA_OUT(rdata_out), .HIGH_OSC_ENABLE_OUT(hi_en), .LOW_OSC_ENABLE_OUT(lo_en),
    .HIGH_OSC_DRIVE_OUT(hi_drv), .LOW_OSC_DRIVE_OUT(lo_drv), .EXTERNAL_CLOCK_OUT(ext_clk),
    .HALT_MODE_OUT(halt), .PLL_CLOCK_OUT(pll_clk), .SYS_CLOCK_OUT(sys_clk), .IRQ_OUT(irq)
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tchk(input string name, input real exp, input real got, input real tol);
    compares++;
    if (got < exp - tol || got > exp + tol)
    begin
      fails++;
      $display("mismatch %s expected %0.1f seen %0.1f", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // Unassigned bits of mapped registers are masked off since their read value is not defined; 16'h10e6 is checked whole
  task automatic rchk(input string name, input logic [15:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(name, e, d & m);
  endtask

  task automatic per(input string name, input real exp);
    realtime t0;
    repeat (2) @(posedge sys_clk);
    t0 = $realtime;
    @(posedge sys_clk);
    tchk(name, exp, $realtime - t0, 40.0);
  endtask

  task automatic poll(input string name, input logic [15:0] a, input int b, input logic v,
                      input real exp, input real tol);
    logic [7:0] d;
    repeat (8000)
    begin
      rd(a, d);
      if (d[b] === v)
      begin
        break;
      end
    end
    tchk(name, exp, $realtime - tw, tol);
  endtask

  task automatic irq_is(input string name, input logic v);
    repeat (3) @(posedge clock_in);
    #1;
    chk(name, {7'h00, v}, {7'h00, irq});
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // The warm-ups dominate at about 150 us; this leaves ample margin
  initial
  begin
    #(600_000);
    fails++;
    results();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    arst_n_in = 1'b0;
    addr_in = 16'h0000;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    fails = 0;
    compares = 0;
    pll_edges = 0;
    repeat (6) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    chk("reset_pins", 8'h1f, {3'h0, hi_en, lo_en, hi_drv, lo_drv, ~ext_clk});
    chk("reset_halt", 8'h03, {6'h00, halt});
    for (int i = 0; i < 9; i++)
    begin
      rchk("reset_value", ra[i], rm[i], re[i]);
    end
    per("reset_period", 32.0 * HP);
    done("reset");

    for (int g = 0; g < 5; g++)
    begin
      wr(ADDR_CLK_SEL, {5'h00, g[2:0]});
      per("gear_period", real'(2 << g) * HP);
    end
    wr(ADDR_CLK_SEL, 8'h07);
    per("gear_reserved", 32.0 * HP);
    done("gear");

    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_WARM_HALT, {2'b00, c[1:0], c[1:0], 2'b00});
      rchk("warm_halt", ADDR_WARM_HALT, 8'h3c, {2'b00, c[1:0], c[1:0], 2'b00});
      chk("halt_mode", {6'h00, c[1:0]}, {6'h00, halt});
      if (c == 0)
      begin
        wr(ADDR_OSC_CTRL, 8'hc4);
        rchk("warm_reserved", ADDR_OSC_CTRL, 8'h04, 8'h00);
      end
    end
    done("warm_codes");

    wr(ADDR_WARM_HALT, 8'h1c);
    tw = $realtime;
    wr(ADDR_OSC_CTRL, 8'hc4);
    wr(ADDR_CLK_SEL, 8'h08);
    rchk("warm_running", ADDR_OSC_CTRL, 8'h04, 8'h04);
    per("deferred_switch", 32.0 * HP);
    poll("warm_to_slow", ADDR_OSC_CTRL, 2, 1'b0, 256.0 * LP, 3.0 * LP);
    rchk("warm_status", ADDR_IRQ_STAT, 8'h01, 8'h01);
    irq_is("irq_masked", 1'b0);
    wr(ADDR_IRQ_MASK, 8'h01);
    irq_is("irq_raised", 1'b1);
    wr(ADDR_IRQ_STAT, 8'h01);
    irq_is("irq_cleared", 1'b0);
    per("slow_period", 2.0 * LP);
    tw = $realtime;
    wr(ADDR_OSC_CTRL, 8'hc4);
    wr(ADDR_CLK_SEL, 8'h04);
    poll("warm_to_fast", ADDR_OSC_CTRL, 2, 1'b0, 256.0 * HP, 3.0 * HP);
    per("fast_period", 32.0 * HP);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h01);
    done("warm_up");

    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_OSC_CTRL, oc[i]);
      #1;
      chk("osc_enables", {6'h00, oc[i][7:6]}, {6'h00, hi_en, lo_en});
    end
    done("oscillators");

    wr(ADDR_EMU_CTRL, 8'h04);
    #1;
    chk("emu_pins", 8'h04, {5'h00, ext_clk, hi_drv, lo_drv});
    wr(ADDR_EMU_CTRL, 8'h03);
    wr(ADDR_KEY_SECOND, KEY_SECOND);
    wr(ADDR_KEY_FIRST, KEY_FIRST);
    rchk("protect_wrong_order", ADDR_EMU_CTRL, 8'h80, 8'h00);
    wr(ADDR_KEY_FIRST, 8'h00);
    wr(ADDR_KEY_SECOND, KEY_SECOND);
    rchk("protect_disarmed", ADDR_EMU_CTRL, 8'h80, 8'h00);
    wr(ADDR_KEY_FIRST, KEY_FIRST);
    wr(ADDR_KEY_SECOND, KEY_SECOND);
    rchk("protect_on", ADDR_EMU_CTRL, 8'h87, 8'h83);
    wr(ADDR_EMU_CTRL, 8'h04);
    rchk("protect_blocks", ADDR_EMU_CTRL, 8'h87, 8'h83);
    wr(ADDR_KEY_FIRST, KEY_FIRST);
    wr(ADDR_KEY_SECOND, KEY_SECOND);
    rchk("protect_off", ADDR_EMU_CTRL, 8'h80, 8'h00);
    done("protect");

    tw = $realtime;
    wr(ADDR_PLL_EN, 8'h80);
    rchk("lock_running", ADDR_PLL_SEL, 8'h60, 8'h00);
    poll("lock_time", ADDR_PLL_SEL, 5, 1'b1, real'(1 << LOCK) * HP, 3.0 * HP);
    pll_edges = 0;
    #(16.0 * HP);
    tchk("pll_edges", 32.0, real'(pll_edges), 2.0);
    rchk("lock_status", ADDR_IRQ_STAT, 8'h02, 8'h02);
    wr(ADDR_IRQ_MASK, 8'h02);
    irq_is("lock_irq", 1'b1);
    wr(ADDR_IRQ_STAT, 8'h02);
    irq_is("lock_irq_clear", 1'b0);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_PLL_SEL, 8'h40);
    rchk("pll_select", ADDR_PLL_SEL, 8'h60, 8'h60);
    per("pll_sys_period", 8.0 * HP);
    wr(ADDR_PLL_SEL, 8'h00);
    wr(ADDR_PLL_EN, 8'h00);
    rchk("pll_stopped", ADDR_PLL_SEL, 8'h60, 8'h00);
    pll_edges = 0;
    #(4.0 * HP);
    tchk("pll_quiet", 0.0, real'(pll_edges), 0.0);
    per("osc_again", 32.0 * HP);
    done("pll");
    results();
  end
endmodule
